/* File: wwd_regs.svh */
`ifndef WWD_REGS_SVH
`define WWD_REGS_SVH

// register byte offsets on the apb window
`define WWD_MODE_OFS 12'h000
`define WWD_TC_OFS 12'h004
`define WWD_FEED_OFS 12'h008
`define WWD_COUNT_OFS 12'h00c
`define WWD_WARN_OFS 12'h010
`define WWD_WINDOW_OFS 12'h014

// mode register bit positions
`define WWD_MODE_EN 0
`define WWD_MODE_RST 1
`define WWD_MODE_PROT 2
`define WWD_MODE_SLEEP 3
`define WWD_MODE_WIN 4
`define WWD_MODE_RSTFLAG 5
`define WWD_MODE_WARNFLAG 6
`define WWD_MODE_TMOFLAG 7

// feed sequence key values
`define WWD_FEED_KEY1 8'haa
`define WWD_FEED_KEY2 8'h55

// counter limits and reset values
`define WWD_TC_MIN 24'h0000ff
`define WWD_TC_RST 24'hffffff
`define WWD_WARN_RST 24'h000000
`define WWD_WIN_RST 24'hffffff

// fixed prescaler: watchdog tick clocks per counter step
`define WWD_PRESCALE_DIV 4
`define WWD_PRESCALE_LAST 2'h3

`endif

/* File: wwd_pkg.sv */
package wwd_pkg;
    // 24-bit counter value
    typedef logic [23:0] wwd_cnt_t;
    // feed sequence tracker
    typedef enum logic [0:0] {
        WWD_FEED_IDLE = 1'b0,
        WWD_FEED_HALF = 1'b1
    } wwd_feed_st_t;
endpackage

/* File: wwd_tick_div.sv */
`timescale 1ns/1ps
`include "wwd_regs.svh"

module wwd_tick_div (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // watchdog tick clock pin and run gate
    input wire logic tick_pin,
    input wire logic run,
    // one-cycle counter step enable
    output logic tick_en
);
    logic sync1_r;
    logic sync2_r;
    logic hist_r;
    logic [1:0] div_r;
    logic rise;

    // two-flop synchroniser, then history flop for edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            hist_r <= 1'b0;
        end else begin
            sync1_r <= tick_pin;
            sync2_r <= sync1_r;
            hist_r <= sync2_r;
        end
    end

    assign rise = sync2_r & ~hist_r;

    // divide rising tick edges by four while running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 2'h0;
            tick_en <= 1'b0;
        end else begin
            tick_en <= rise & run & (div_r == `WWD_PRESCALE_LAST);
            if (rise & run) begin
                div_r <= div_r + 2'h1;
            end
        end
    end
endmodule

/* File: wwd_top.sv */
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`include "wwd_regs.svh"

// Function
// - once enabled, missing a feed before time-out produces a watchdog event
// - time-out either resets the chip or only raises an interrupt, by mode bit
// - with windowing on, a feed counts only between window and time-out
// - warning interrupt raised when the counter reaches a programmable value
// - 24-bit counter steps once per four watchdog tick clocks
// - period from 256 steps (1,024 ticks) up to 2^24 steps, four ticks each
// - enable cannot be cleared by software, only by reset or watchdog reset
// - a bad feed sequence while enabled fires the watchdog event at once
// - optional protection ignores reload writes until the warning point is reached
// - a flag records that a watchdog reset has happened
// - counter may keep running in deep sleep from the tick clock
module wwd_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // watchdog tick clock pin and power state
    input wire logic tick_pin,
    input wire logic deep_sleep,
    // event outputs
    output logic wdt_reset,
    output logic warn_irq,
    output logic tmo_irq,
    // live counter value
    output wwd_pkg::wwd_cnt_t wdt_count
);
    import wwd_pkg::*;

    logic mode_en_r;
    logic mode_rst_r;
    logic mode_prot_r;
    logic mode_sleep_r;
    logic mode_win_r;
    logic rst_flag_r;
    logic warn_flag_r;
    logic tmo_flag_r;
    wwd_cnt_t tc_r;
    wwd_cnt_t warn_r;
    wwd_cnt_t win_r;
    wwd_cnt_t count_r;
    wwd_cnt_t count_dec;
    wwd_cnt_t tc_wr;
    wwd_feed_st_t feed_st_r;
    wwd_feed_st_t feed_st_nxt;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic wdt_reset_r;
    logic run;
    logic tick_en;
    logic access;
    logic setup;
    logic wr;
    logic mapped;
    logic wr_mode;
    logic wr_tc;
    logic wr_feed;
    logic wr_warn;
    logic wr_win;
    logic feed_try;
    logic feed_ok;
    logic bad_feed;
    logic tmo_hit;
    logic warn_hit;
    logic wd_event;
    logic rst_evt;
    logic irq_evt;
    logic tc_locked;

    // counter runs only when enabled, and in deep sleep only if allowed
    // pausing here also freezes the prescaler phase, so no partial step is lost
    assign run = mode_en_r & (~deep_sleep | mode_sleep_r);

    // tick clock sync and fixed divide-by-four prescaler
    // the tick pin is asynchronous, so nothing here reads it before two flops
    wwd_tick_div u_tick_div (
        .pclk(pclk),
        .presetn(presetn),
        .tick_pin(tick_pin),
        .run(run),
        .tick_en(tick_en)
    );

    // apb phase decode
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign mapped = (paddr == `WWD_MODE_OFS) | (paddr == `WWD_TC_OFS) |
                    (paddr == `WWD_FEED_OFS) | (paddr == `WWD_COUNT_OFS) |
                    (paddr == `WWD_WARN_OFS) | (paddr == `WWD_WINDOW_OFS);
    assign wr_mode = wr & (paddr == `WWD_MODE_OFS);
    assign wr_tc = wr & (paddr == `WWD_TC_OFS);
    assign wr_feed = wr & (paddr == `WWD_FEED_OFS);
    assign wr_warn = wr & (paddr == `WWD_WARN_OFS);
    assign wr_win = wr & (paddr == `WWD_WINDOW_OFS);

    // slave always answers in the access phase without wait states
    // read data is latched at setup so the access phase sees a settled word
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r & access;

    // feed sequence tracker: first key arms, very next access must be the second key
    // any access in between, read or write, to any address, breaks the sequence
    always_comb begin
        feed_st_nxt = feed_st_r;
        feed_try = 1'b0;
        bad_feed = 1'b0;
        unique case (feed_st_r)
            WWD_FEED_IDLE: begin
                if (wr_feed) begin
                    if (pwdata[7:0] == `WWD_FEED_KEY1) begin
                        feed_st_nxt = WWD_FEED_HALF;
                    end else begin
                        bad_feed = 1'b1;
                    end
                end
            end
            WWD_FEED_HALF: begin
                if (access) begin
                    feed_st_nxt = WWD_FEED_IDLE;
                    if (wr_feed & (pwdata[7:0] == `WWD_FEED_KEY2)) begin
                        feed_try = 1'b1;
                    end else begin
                        bad_feed = 1'b1;
                    end
                end
            end
        endcase
        // feeding before the window opens is also a bad feed
        if (feed_try & mode_win_r & (count_r > win_r)) begin
            feed_try = 1'b0;
            bad_feed = 1'b1;
        end
    end

    assign feed_ok = feed_try;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            feed_st_r <= WWD_FEED_IDLE;
        end else begin
            feed_st_r <= feed_st_nxt;
        end
    end

    // time-out and warning detection on counter steps
    // warning fires on the step that lands on the level, never on the zero step
    assign count_dec = count_r - 24'h000001;
    assign tmo_hit = tick_en & (count_r == 24'h000000);
    assign warn_hit = tick_en & (count_r != 24'h000000) & (count_dec == warn_r);

    // bad feed only matters while enabled; it fires without waiting
    // a disabled watchdog still tracks keys so a later enable starts clean
    assign wd_event = mode_en_r & (tmo_hit | bad_feed);
    assign rst_evt = wd_event & mode_rst_r;
    assign irq_evt = wd_event & ~mode_rst_r;

    // down counter: reload on feed or event, else step on prescaled tick
    // the reload has priority so a feed on a step edge is never lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= `WWD_TC_RST;
        end else if (feed_ok | wd_event) begin
            count_r <= tc_r;
        end else if (tick_en) begin
            count_r <= count_dec;
        end
    end

    assign wdt_count = count_r;

    // enable is set-only from software; a watchdog reset clears it
    // writing zero to the enable bit is simply ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_en_r <= 1'b0;
        end else if (rst_evt) begin
            mode_en_r <= 1'b0;
        end else if (wr_mode & pwdata[`WWD_MODE_EN]) begin
            mode_en_r <= 1'b1;
        end
    end

    // plain mode option bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_rst_r <= 1'b0;
            mode_prot_r <= 1'b0;
            mode_sleep_r <= 1'b0;
            mode_win_r <= 1'b0;
        end else if (wr_mode) begin
            mode_rst_r <= pwdata[`WWD_MODE_RST];
            mode_prot_r <= pwdata[`WWD_MODE_PROT];
            mode_sleep_r <= pwdata[`WWD_MODE_SLEEP];
            mode_win_r <= pwdata[`WWD_MODE_WIN];
        end
    end

    // sticky flags, write one to clear, a new event wins over the clear
    // set-wins keeps an event that races a clear from vanishing unseen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_flag_r <= 1'b0;
            warn_flag_r <= 1'b0;
            tmo_flag_r <= 1'b0;
        end else begin
            if (rst_evt) begin
                rst_flag_r <= 1'b1;
            end else if (wr_mode & pwdata[`WWD_MODE_RSTFLAG]) begin
                rst_flag_r <= 1'b0;
            end
            if (warn_hit & mode_en_r) begin
                warn_flag_r <= 1'b1;
            end else if (wr_mode & pwdata[`WWD_MODE_WARNFLAG]) begin
                warn_flag_r <= 1'b0;
            end
            if (irq_evt) begin
                tmo_flag_r <= 1'b1;
            end else if (wr_mode & pwdata[`WWD_MODE_TMOFLAG]) begin
                tmo_flag_r <= 1'b0;
            end
        end
    end

    assign warn_irq = warn_flag_r;
    assign tmo_irq = tmo_flag_r;

    // reset request pulse, one cycle per reset-mode event
    // registered so the request leaves the block glitch-free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_reset_r <= 1'b0;
        end else begin
            wdt_reset_r <= rst_evt;
        end
    end

    assign wdt_reset = wdt_reset_r;

    // reload value: clamp to minimum, optionally locked until warning point
    // clamping keeps the shortest period at 256 steps whatever is written
    assign tc_locked = mode_prot_r & (count_r > warn_r);
    assign tc_wr = (pwdata[23:0] < `WWD_TC_MIN) ? `WWD_TC_MIN : pwdata[23:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tc_r <= `WWD_TC_RST;
        end else if (wr_tc & ~tc_locked) begin
            tc_r <= tc_wr;
        end
    end

    // warning and window compare values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warn_r <= `WWD_WARN_RST;
            win_r <= `WWD_WIN_RST;
        end else begin
            if (wr_warn) begin
                warn_r <= pwdata[23:0];
            end
            if (wr_win) begin
                win_r <= pwdata[23:0];
            end
        end
    end

    // read data and error captured in the setup phase
    // unmapped offsets read as zero and flag an error in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            pslverr_r <= ~mapped;
            prdata_r <= 32'h00000000;
            if (!pwrite) begin
                unique case (paddr)
                    `WWD_MODE_OFS: prdata_r <= {24'h000000, tmo_flag_r, warn_flag_r,
                        rst_flag_r, mode_win_r, mode_sleep_r, mode_prot_r,
                        mode_rst_r, mode_en_r};
                    `WWD_TC_OFS: prdata_r <= {8'h00, tc_r};
                    `WWD_COUNT_OFS: prdata_r <= {8'h00, count_r};
                    `WWD_WARN_OFS: prdata_r <= {8'h00, warn_r};
                    `WWD_WINDOW_OFS: prdata_r <= {8'h00, win_r};
                    default: prdata_r <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

/* File: wwd_props.sv */
`timescale 1ns/1ps
`include "wwd_regs.svh"
module wwd_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // tick pin and power state
    input wire logic tick_pin,
    input wire logic deep_sleep,
    // events and counter
    input wire logic wdt_reset,
    input wire logic warn_irq,
    input wire logic tmo_irq,
    input wire wwd_pkg::wwd_cnt_t wdt_count
);
    import wwd_pkg::*;
    logic acc, map, mw;
    wwd_cnt_t warn_r;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // decoded apb access
    assign acc = psel & penable;
    assign mw = acc & pwrite & (paddr == `WWD_MODE_OFS);
    assign map = paddr inside {`WWD_MODE_OFS, `WWD_TC_OFS, `WWD_FEED_OFS,
        `WWD_COUNT_OFS, `WWD_WARN_OFS, `WWD_WINDOW_OFS};
    // shadow of the warning level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warn_r <= `WWD_WARN_RST;
        end else if (acc && pwrite && paddr == `WWD_WARN_OFS) begin
            warn_r <= pwdata[23:0];
        end
    end
    a_step_spacing: assert property ((wdt_count == $past(wdt_count) - 24'h1) |=>
        (wdt_count != $past(wdt_count) - 24'h1) [*8]) else $error("steps too close");
    a_count_cause: assert property ($changed(wdt_count) |->
        wdt_count == $past(wdt_count) - 24'h1 || $past(wdt_count) == 24'h0
        || $past(acc) || $past(acc, 2)) else $error("count jumped");
    a_reset_pulse: assert property (wdt_reset |=> !wdt_reset)
        else $error("reset pulse too long");
    a_reset_cause: assert property ($rose(wdt_reset) |->
        $past(wdt_count) == 24'h0 || $past(wdt_count, 2) == 24'h0
        || $past(acc) || $past(acc, 2)) else $error("reset without cause");
    a_warn_sticky: assert property ($fell(warn_irq) |->
        $past(mw && pwdata[`WWD_MODE_WARNFLAG])) else $error("warn lost");
    a_tmo_sticky: assert property ($fell(tmo_irq) |->
        $past(mw && pwdata[`WWD_MODE_TMOFLAG])) else $error("tmo lost");
    a_tmo_cause: assert property ($rose(tmo_irq) |-> !wdt_reset &&
        ($past(wdt_count) == 24'h0 || $past(acc))) else $error("tmo without cause");
    a_warn_point: assert property ($rose(warn_irq) |->
        wdt_count == warn_r || $past(wdt_count) == warn_r) else $error("warn off point");
    a_slverr_map: assert property (acc |-> pslverr == !map) else $error("bad slverr");
    a_unmapped_zero: assert property (acc && !pwrite && !map |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    // main scenarios
    c_reset: cover property ($rose(wdt_reset));
    c_tmo: cover property ($rose(tmo_irq));
    c_warn: cover property ($rose(warn_irq));
endmodule

bind wwd_top wwd_props wwd_props_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tick_pin, .deep_sleep,
    .wdt_reset, .warn_irq, .tmo_irq, .wdt_count);

/* File: tb_top.sv */
`timescale 1ns/1ps
`include "wwd_regs.svh"
module tb_top;
    import wwd_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdv, ev;
    logic pready, pslverr, sv, ph = 0, rst_seen;
    logic tick_pin = 0, deep_sleep = 0, tick_on = 0;
    logic wdt_reset, warn_irq, tmo_irq;
    wwd_cnt_t wdt_count;
    int bad_count = 0, num_checks = 0;
    assign ev = {29'h0, tmo_irq, warn_irq, wdt_reset};
    // bus clock and slow tick pin, tick period four bus clocks
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        ph <= ~ph;
        if (tick_on && ph) tick_pin <= ~tick_pin;
    end
    // remembers any reset pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) rst_seen <= 1'b0;
        else if (wdt_reset === 1'b1) rst_seen <= 1'b1;
    end
    wwd_top wwd_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .tick_pin, .deep_sleep,
        .wdt_reset, .warn_irq, .tmo_irq, .wdt_count);
    // shared helpers
    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        sv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask
    task feed;
        wr(`WWD_FEED_OFS, 32'(`WWD_FEED_KEY1));
        wr(`WWD_FEED_OFS, 32'(`WWD_FEED_KEY2));
    endtask
    task wt(input int k, input int n);
        repeat (n) begin
            @(negedge pclk);
            if (ev[k] === 1'b1) break;
        end
    endtask
    task do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        tick_on <= 1'b0;
        deep_sleep <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    // scenarios
    task t_rst;
        do_reset();
        rd(`WWD_MODE_OFS, 32'h0);
        rd(`WWD_TC_OFS, 32'hffffff);
        rd(`WWD_WARN_OFS, 32'h0);
        rd(`WWD_WINDOW_OFS, 32'hffffff);
        rd(`WWD_COUNT_OFS, 32'hffffff);
        rd(12'h018, 32'h0);
        chk({31'h0, sv}, 32'h1);
    endtask
    task t_lock;
        do_reset();
        wr(`WWD_TC_OFS, 32'h10);
        rd(`WWD_TC_OFS, 32'hff);
        wr(`WWD_MODE_OFS, 32'h1);
        wr(`WWD_MODE_OFS, 32'h0);
        rd(`WWD_MODE_OFS, 32'h1);
        feed();
        rd(`WWD_COUNT_OFS, 32'hff);
        chk({8'h0, wdt_count}, 32'hff);
    endtask
    task t_bad;
        do_reset();
        wr(`WWD_MODE_OFS, 32'h3);
        wr(`WWD_FEED_OFS, 32'(`WWD_FEED_KEY1));
        wr(`WWD_FEED_OFS, 32'h12);
        wt(0, 4);
        chk(ev, 32'h1);
        rd(`WWD_MODE_OFS, 32'h22);
        wr(`WWD_MODE_OFS, 32'h3);
        wr(`WWD_FEED_OFS, 32'(`WWD_FEED_KEY1));
        rd(`WWD_COUNT_OFS, 32'hffffff);
        wt(0, 4);
        chk(ev, 32'h1);
        wr(`WWD_MODE_OFS, 32'h20);
        rd(`WWD_MODE_OFS, 32'h0);
    endtask
    task t_irq;
        do_reset();
        wr(`WWD_TC_OFS, 32'h100);
        wr(`WWD_WARN_OFS, 32'h80);
        wr(`WWD_MODE_OFS, 32'h1);
        feed();
        tick_on <= 1'b1;
        repeat (1950) @(negedge pclk);
        chk(ev, 32'h0);
        wt(1, 200);
        chk(ev, 32'h2);
        repeat (1950) @(negedge pclk);
        chk(ev, 32'h2);
        wt(2, 200);
        chk(ev, 32'h6);
        chk({31'h0, rst_seen}, 32'h0);
        wr(`WWD_MODE_OFS, 32'hc1);
        @(negedge pclk);
        chk(ev, 32'h0);
    endtask
    task t_rstmode;
        do_reset();
        wr(`WWD_TC_OFS, 32'hff);
        feed();
        deep_sleep <= 1'b1;
        wr(`WWD_MODE_OFS, 32'h3);
        tick_on <= 1'b1;
        repeat (200) @(posedge pclk);
        rd(`WWD_COUNT_OFS, 32'hff);
        wr(`WWD_MODE_OFS, 32'h0b);
        wt(0, 4300);
        chk(ev, 32'h3);
        rd(`WWD_MODE_OFS, 32'h6a);
    endtask
    task t_win;
        do_reset();
        wr(`WWD_TC_OFS, 32'hff);
        feed();
        wr(`WWD_WINDOW_OFS, 32'hf0);
        wr(`WWD_MODE_OFS, 32'h13);
        tick_on <= 1'b1;
        repeat (300) @(posedge pclk);
        feed();
        repeat (2) @(posedge pclk);
        chk({31'h0, rst_seen}, 32'h0);
        feed();
        wt(0, 4);
        chk(ev, 32'h1);
    endtask
    task t_prot;
        do_reset();
        wr(`WWD_TC_OFS, 32'h100);
        wr(`WWD_WARN_OFS, 32'hf8);
        wr(`WWD_MODE_OFS, 32'h5);
        feed();
        wr(`WWD_TC_OFS, 32'h200);
        rd(`WWD_TC_OFS, 32'h100);
        tick_on <= 1'b1;
        repeat (200) @(posedge pclk);
        wr(`WWD_TC_OFS, 32'h200);
        rd(`WWD_TC_OFS, 32'h200);
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        end_of_test();
    end
    // main sequence
    initial begin
        t_rst();
        t_lock();
        t_bad();
        t_irq();
        t_rstmode();
        t_win();
        t_prot();
        end_of_test();
    end
endmodule
